// *** hw/awtc_top.sv ***
/*
  area wait timing control: apb register slave plus the external bus
  sequencer for one area holding normal space or byte-selection sram.
  assumes pclk is twice the external bus clock, the memory and wait pins
  are asynchronous to pclk, and user requests come from pclk logic.
*/
// Chosen here: the placing of the registers and the APB interface to the registers.
// Operation
// - wait control fields are read according to the area memory kind
// - this layout applies for normal space and byte-selection sram only
// - strobes follow address and select by 0.5 to 3.5 cycles
// - access wait code gives 0-6, 8, 10, 12, 14, 18 or 24 cycles
// - wait mask 0 honours the external wait input, 1 ignores it
// - the wait mask also acts when the wait count is zero
// - address and select stay 0.5 to 3.5 cycles after strobe negation
// - reserved bits read zero and software writes zero there
// - memory kind 0000 is normal space and 0011 byte-selection sram
`timescale 1ns/1ps

module awtc_top
  import awtc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [23:0] req_addr,
  input wire logic [1:0] req_be,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [15:0] rsp_rdata,
  output logic mem_clk,
  output logic [23:0] mem_addr,
  output logic area_select_n,
  output logic read_strobe_n,
  output logic [1:0] byte_lane_strobe_n,
  output logic write_status_n,
  output logic [15:0] mem_dq_o,
  output logic mem_dq_oe,
  input wire logic [15:0] mem_dq_i,
  input wire logic ext_wait_n
);

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  awtc_regs_t q;
  awtc_regs_t d;
  logic [4:0] wait_cyc;
  logic sel_wcr;
  logic sel_bcr;
  logic apb_write;
  logic accept;
  logic [3:0] kind;

  // access wait code decode for the live register
  // wait code decode
  awtc_wait_lut u_wait_lut (
    .code(q.wcr[`AWTC_WAIT_HI:`AWTC_WAIT_LO]),
    .cycles(wait_cyc),
    // reserved codes already clamp to the longest step
    .legal()
  );

  // address decode and transfer strobes
  assign sel_wcr = (paddr == `AWTC_WCR_OFF);
  assign sel_bcr = (paddr == `AWTC_BCR_OFF);
  assign apb_write = psel && penable && pwrite && (sel_wcr || sel_bcr);
  assign kind = q.bcr[`AWTC_KIND_HI:`AWTC_KIND_LO];
  // requests start only on a rising bus clock edge
  assign accept = req_valid && req_ready;

  // ----------------------------------------------------------------
  // apb handshake outputs
  // ----------------------------------------------------------------
  // zero-wait slave, unmapped offsets answer with an error
  // pready never drops, so every access phase is one cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(sel_wcr || sel_bcr);
  assign prdata = q.prdata;

  // ----------------------------------------------------------------
  // user and pin outputs
  // ----------------------------------------------------------------
  // new request only at a rising bus edge with no answer pending
  assign req_ready = (q.st == AWTC_IDLE) && !q.ph && !q.rsp_valid;
  assign rsp_valid = q.rsp_valid;
  assign rsp_error = q.rsp_err;
  assign rsp_rdata = q.rdata;
  assign mem_clk = q.ph;
  assign mem_addr = q.addr;
  assign area_select_n = q.cs_n;
  assign read_strobe_n = q.rd_n;
  assign byte_lane_strobe_n = q.lane_n;
  assign write_status_n = q.status_n;
  assign mem_dq_o = q.wdata;
  assign mem_dq_oe = q.oe;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.rsp_valid = 1'b0;

    // synchronisers for the asynchronous pins
    // only the second flop of each pair feeds the logic
    d.wsync1 = ext_wait_n;
    d.wsync2 = q.wsync1;
    d.dsync1 = mem_dq_i;
    d.dsync2 = q.dsync1;

    // divider: one pclk per half bus cycle
    // half bus cycle phase
    d.ph = !q.ph;

    // register read data, loaded in the setup phase
    // reserved bits read zero
    if (psel && !penable)
    begin
      if (sel_wcr)
        d.prdata = q.wcr & `AWTC_WCR_MASK;
      else if (sel_bcr)
        d.prdata = q.bcr & `AWTC_BCR_MASK;
      else
        d.prdata = `AWTC_ZERO32;
    end

    // register writes, reserved bits dropped
    // reserved bits never stored
    if (apb_write && sel_wcr)
      d.wcr = pwdata & `AWTC_WCR_MASK;
    if (apb_write && sel_bcr)
      d.bcr = pwdata & `AWTC_BCR_MASK;

    case (q.st)
      AWTC_IDLE:
      begin
        if (accept)
        begin
          if (!awtc_kind_ok(kind))
          begin
            d.st = AWTC_FAIL;
          end
          else
          begin
            // snapshot timing so a register write cannot tear a cycle
            // kind codes select strobe style
            d.bytesel = (kind == `AWTC_KIND_BYTESEL);
            d.mask = q.wcr[`AWTC_MASK_BIT];
            d.hold_sel = q.wcr[`AWTC_HOLD_HI:`AWTC_HOLD_LO];
            d.wait_cyc = wait_cyc;
            d.write = req_write;
            d.be = req_be;
            d.addr = req_addr;
            d.wdata = req_wdata;
            d.cs_n = 1'b0;
            // write status and data drive span the whole write cycle
            d.status_n = !req_write;
            d.oe = req_write;
            d.cnt = {3'h0, q.wcr[`AWTC_SETUP_HI:`AWTC_SETUP_LO], 1'b1};
            d.st = AWTC_SETUP;
          end
        end
      end

      AWTC_SETUP:
      begin
        if (q.cnt == `AWTC_CNT_ONE)
        begin
          // strobes land on the falling bus edge
          // strobes on opposite edge
          d.rd_n = q.write;
          if (q.write || q.bytesel)
            d.lane_n = ~q.be;
          // strobe for one plus wait cycles
          d.cnt = {q.wait_cyc + 5'h01, 1'b0};
          d.st = AWTC_ACCESS;
        end
        else
        begin
          d.cnt = q.cnt - `AWTC_CNT_ONE;
        end
      end

      AWTC_ACCESS:
      begin
        if (q.cnt == `AWTC_CNT_ONE)
        begin
          // applies with zero wait count too
          if (!q.mask && !q.wsync2)
          begin
            // one bus cycle more per sampled wait
            d.cnt = `AWTC_EXT_HALF;
          end
          else
          begin
            d.rd_n = 1'b1;
            d.lane_n = 2'b11;
            d.rdata = q.write ? 16'h0000 : q.dsync2;
            d.cnt = {3'h0, q.hold_sel, 1'b1};
            d.st = AWTC_HOLD;
          end
        end
        else
        begin
          d.cnt = q.cnt - `AWTC_CNT_ONE;
        end
      end

      AWTC_HOLD:
      begin
        if (q.cnt == `AWTC_CNT_ONE)
        begin
          d.cs_n = 1'b1;
          d.status_n = 1'b1;
          d.oe = 1'b0;
          // answer pulses as the select is released
          d.rsp_valid = 1'b1;
          d.rsp_err = 1'b0;
          d.st = AWTC_IDLE;
        end
        else
        begin
          d.cnt = q.cnt - `AWTC_CNT_ONE;
        end
      end

      AWTC_FAIL:
      begin
        // other kinds get no bus cycle
        // no pin other than mem_clk moves, but the user still gets one answer
        d.rsp_valid = 1'b1;
        d.rsp_err = 1'b1;
        d.rdata = 16'h0000;
        d.st = AWTC_IDLE;
      end

      default:
      begin
        d.st = AWTC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // asynchronous clear to constants, then the whole record
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q.wcr <= `AWTC_WCR_RESET;
      q.bcr <= `AWTC_BCR_RESET;
      q.prdata <= `AWTC_ZERO32;
      q.ph <= 1'b0;
      q.st <= AWTC_IDLE;
      q.cnt <= 6'h00;
      q.mask <= 1'b0;
      q.hold_sel <= 2'b00;
      q.wait_cyc <= 5'h00;
      q.bytesel <= 1'b0;
      q.write <= 1'b0;
      q.be <= 2'b00;
      q.addr <= 24'h000000;
      q.wdata <= 16'h0000;
      q.cs_n <= 1'b1;
      q.rd_n <= 1'b1;
      q.lane_n <= 2'b11;
      q.status_n <= 1'b1;
      q.oe <= 1'b0;
      q.rsp_valid <= 1'b0;
      q.rsp_err <= 1'b0;
      q.rdata <= 16'h0000;
      q.wsync1 <= 1'b1;
      q.wsync2 <= 1'b1;
      q.dsync1 <= 16'h0000;
      q.dsync2 <= 16'h0000;
    end
    else
    begin
      q <= d;
    end
  end

endmodule : awtc_top

// *** hw/awtc_consts.svh ***
/*
  constants for the area wait timing control block: register offsets,
  field positions, reset values and timing figures.
  assumes it is included by bare name from the package and the bench.
*/
`ifndef AWTC_CONSTS_SVH
`define AWTC_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define AWTC_ADDR_W 12
`define AWTC_WCR_OFF 12'h000
`define AWTC_BCR_OFF 12'h004
`define AWTC_WCR_RESET 32'h0000_0500
`define AWTC_WCR_MASK 32'h0000_1fc3
`define AWTC_BCR_RESET 32'h0000_0000
`define AWTC_BCR_MASK 32'h0000_f000
`define AWTC_ZERO32 32'h0000_0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AWTC_SETUP_HI 12
`define AWTC_SETUP_LO 11
`define AWTC_WAIT_HI 10
`define AWTC_WAIT_LO 7
`define AWTC_MASK_BIT 6
`define AWTC_HOLD_HI 1
`define AWTC_HOLD_LO 0
`define AWTC_KIND_HI 15
`define AWTC_KIND_LO 12

// ----------------------------------------------------------------
// memory kind codes
// ----------------------------------------------------------------
`define AWTC_KIND_NORMAL 4'h0
`define AWTC_KIND_BYTESEL 4'h3

// ----------------------------------------------------------------
// timing: pclk period in ns, counter steps in pclk half bus cycles, longest wait in bus cycles
// ----------------------------------------------------------------
`define AWTC_PCLK_NS 4
`define AWTC_CNT_ONE 6'h01
`define AWTC_EXT_HALF 6'h02
`define AWTC_WAIT_MAX 5'h18

`endif

// *** hw/awtc_pkg.sv ***
/*
  types shared by the area wait timing control design.
  assumes awtc_consts.svh is reachable on the include path.
*/
`include "awtc_consts.svh"

package awtc_pkg;

  // ----------------------------------------------------------------
  // state machine and state record
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {AWTC_IDLE, AWTC_SETUP, AWTC_ACCESS, AWTC_HOLD, AWTC_FAIL} awtc_state_t;

  typedef struct packed {
    logic [31:0] wcr;
    logic [31:0] bcr;
    logic [31:0] prdata;
    logic ph;
    awtc_state_t st;
    logic [5:0] cnt;
    logic mask;
    logic [1:0] hold_sel;
    logic [4:0] wait_cyc;
    logic bytesel;
    logic write;
    logic [1:0] be;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic cs_n;
    logic rd_n;
    logic [1:0] lane_n;
    logic status_n;
    logic oe;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rdata;
    logic wsync1;
    logic wsync2;
    logic [15:0] dsync1;
    logic [15:0] dsync2;
  } awtc_regs_t;

  // true when the field layout of this block applies to the kind
  function automatic logic awtc_kind_ok(input logic [3:0] kind);
    awtc_kind_ok = (kind == `AWTC_KIND_NORMAL) || (kind == `AWTC_KIND_BYTESEL);
  endfunction : awtc_kind_ok

endpackage : awtc_pkg

// *** hw/awtc_wait_lut.sv ***
/*
  decoder from the four-bit access wait code to a count of bus cycles.
  assumes a purely combinational use by the top module.
*/
`timescale 1ns/1ps

module awtc_wait_lut
  import awtc_pkg::*;
(
  input wire logic [3:0] code,
  output logic [4:0] cycles,
  output logic legal
);

  // ----------------------------------------------------------------
  // code to cycles
  // ----------------------------------------------------------------
  // linear up to six, then the stretched steps; reserved codes clamp long
  always_comb
  begin
    legal = 1'b1;
    case (code)
      4'h0: cycles = 5'h00;
      4'h1: cycles = 5'h01;
      4'h2: cycles = 5'h02;
      4'h3: cycles = 5'h03;
      4'h4: cycles = 5'h04;
      4'h5: cycles = 5'h05;
      4'h6: cycles = 5'h06;
      4'h7: cycles = 5'h08;
      4'h8: cycles = 5'h0a;
      4'h9: cycles = 5'h0c;
      4'ha: cycles = 5'h0e;
      4'hb: cycles = 5'h12;
      4'hc: cycles = 5'h18;
      default:
      begin
        cycles = `AWTC_WAIT_MAX;
        legal = 1'b0;
      end
    endcase
  end

endmodule : awtc_wait_lut

// *** tb/awtc_monitor.sv ***
/*
  assertions on the ports of awtc_top, one clock domain.
  assumes it is bound to awtc_top from the bench top file.
*/
`timescale 1ns/1ps
module awtc_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic area_select_n,
  input wire logic read_strobe_n,
  input wire logic [1:0] byte_lane_strobe_n,
  input wire logic write_status_n,
  input wire logic mem_clk,
  input wire logic mem_dq_oe
);
  logic [12:0] wcr_q;
  logic [12:0] snap_q;
  logic [3:0] kind_q;
  logic [6:0] cnt_q;
  wire stb_n = read_strobe_n & (&byte_lane_strobe_n);
  wire take = req_valid & req_ready;
  wire apw = psel & penable & pwrite;

  // strobe low span in half cycles for a wait code
  function automatic logic [6:0] span(input logic [3:0] c);
    case (c)
      4'h7: span = 7'h12;
      4'h8: span = 7'h16;
      4'h9: span = 7'h1a;
      4'ha: span = 7'h1e;
      4'hb: span = 7'h26;
      4'hc: span = 7'h32;
      default: span = {2'h0, c, 1'b0} + 7'h02;
    endcase
  endfunction : span

  // shadow fields, snapshot at accept, phase counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wcr_q <= 13'h0500;
      kind_q <= 4'h0;
      snap_q <= 13'h0000;
      cnt_q <= 7'h00;
    end
    else
    begin
      if (apw && paddr == 12'h000)
        wcr_q <= pwdata[12:0] & 13'h1fc3;
      if (apw && paddr == 12'h004)
        kind_q <= pwdata[15:12];
      if (take)
        snap_q <= wcr_q;
      if ($fell(area_select_n) || $changed(stb_n))
        cnt_q <= 7'h01;
      else if (cnt_q != 7'h7f)
        cnt_q <= cnt_q + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_err_seen;
    ##[1:3] (rsp_valid && rsp_error);
  endsequence
  AST_SEL_FIRST: assert property ($fell(area_select_n) |-> stb_n)
    else $error("strobe with select");
  AST_SETUP_DLY: assert property ($fell(stb_n) |-> cnt_q == {4'h0, snap_q[12:11], 1'b1})
    else $error("setup delay");
  AST_WAIT_CNT: assert property ($rose(stb_n) && snap_q[6] |-> cnt_q == span(snap_q[10:7]))
    else $error("wait span");
  AST_WAIT_EXT: assert property ($rose(stb_n) && !snap_q[6] |-> cnt_q >= span(snap_q[10:7]))
    else $error("unmasked wait span");
  AST_HOLD_DLY: assert property ($rose(area_select_n) |-> cnt_q == {4'h0, snap_q[1:0], 1'b1})
    else $error("hold delay");
  AST_RSP_END: assert property ($rose(area_select_n) |-> rsp_valid && !rsp_error)
    else $error("response at end");
  AST_KIND_ERR: assert property (take && !(kind_q == 4'h0 || kind_q == 4'h3)
    |-> area_select_n throughout s_err_seen)
    else $error("kind refusal");
  AST_RD_WCR: assert property (psel && penable && !pwrite && paddr == 12'h000
    |-> prdata == {19'h0, wcr_q})
    else $error("wait control read");
  AST_SEL_RISE: assert property ($fell(area_select_n) |-> mem_clk)
    else $error("select off rising bus edge");
  AST_STB_FALL: assert property ($fell(stb_n) |-> !mem_clk)
    else $error("strobe off falling bus edge");
  AST_STB_IN_SEL: assert property (!stb_n |-> !area_select_n && mem_dq_oe == !write_status_n)
    else $error("strobe outside select");
endmodule : awtc_monitor

// *** tb/awtc_sram_model.sv ***
/*
  sram model on the far side of awtc_top.
  assumes pclk and slow come from the bench.
*/
`timescale 1ns/1ps
module awtc_sram_model
(
  input wire logic pclk,
  input wire logic slow,
  input wire logic [23:0] mem_addr,
  input wire logic area_select_n,
  input wire logic [1:0] byte_lane_strobe_n,
  input wire logic write_status_n,
  input wire logic [15:0] mem_dq_o,
  output logic [15:0] mem_dq_i,
  output logic ext_wait_n
);
  logic [15:0] mem [16];
  logic [15:0] last_q = 16'h0000;
  logic [1:0] lane_q = 2'h3;
  logic [3:0] wcnt_q = 4'h0;
  // output enabled by select on read cycles, ahead of any strobe
  wire drive = !area_select_n && write_status_n;
  // ----------------------------------------------------------------
  // storage, wait and read drive
  // ----------------------------------------------------------------
  // lane write on strobe rise, wait count since select
  always @(posedge pclk)
  begin
    lane_q <= byte_lane_strobe_n;
    for (int b = 0; b < 2; b++)
      if (byte_lane_strobe_n[b] && !lane_q[b] && !write_status_n)
        mem[mem_addr[3:0]][b*8 +: 8] <= mem_dq_o[b*8 +: 8];
    wcnt_q <= area_select_n ? 4'h0 : wcnt_q + {3'h0, wcnt_q != 4'hf};
    if (drive)
      last_q <= mem_dq_i;
  end
  // released bus shows the inverse of the last value
  assign mem_dq_i = drive ? mem[mem_addr[3:0]] : ~last_q;
  assign ext_wait_n = !(slow && !area_select_n && wcnt_q < 4'h8);
endmodule : awtc_sram_model

// *** tb/awtc_top_bench.sv ***
/*
  self-checking bench for awtc_top: apb and access tasks, tests.
  assumes package, design, model and monitor are compiled first.
*/
`timescale 1ns/1ps
`include "awtc_consts.svh"
module awtc_top_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic slow = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [23:0] req_addr = 24'h0, mem_addr;
  logic [1:0] req_be = 2'h3, byte_lane_strobe_n;
  logic [15:0] req_wdata = 16'h0, rsp_rdata, mem_dq_o, mem_dq_i;
  logic pready, pslverr, err, req_ready, rsp_valid, rsp_error, mem_clk;
  logic area_select_n, read_strobe_n, write_status_n, mem_dq_oe, ext_wait_n;
  int mismatches = 0, tests_run = 0, lat;
  logic [4:0] wc_tab [13] = '{5'h0, 5'h1, 5'h2, 5'h3, 5'h4, 5'h5, 5'h6, 5'h8, 5'ha, 5'hc, 5'he, 5'h12, 5'h18};

  awtc_top dut_u (.*);
  awtc_sram_model mem_u (.*);
  // clock, 4 ns period
  always #2 pclk = ~pclk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ready checked at the falling edge, taken at the next rise
  task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do @(negedge pclk); while (req_ready !== 1'b1);
    @(posedge pclk);
    req_valid <= 1'b0;
    lat = 0;
    do
    begin
      @(negedge pclk);
      lat++;
    end
    while (rsp_valid !== 1'b1);
  endtask : acc

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `AWTC_WCR_OFF, 32'h0);
    chk("wcr reset", rd, `AWTC_WCR_RESET);
    apb(1'b1, `AWTC_WCR_OFF, 32'hffff_fe7f);
    apb(1'b0, `AWTC_WCR_OFF, 32'h0);
    chk("wcr reserved", rd, 32'h0000_1e43);
    apb(1'b1, `AWTC_BCR_OFF, 32'hffff_ffff);
    apb(1'b0, `AWTC_BCR_OFF, 32'h0);
    chk("bcr reserved", rd, 32'h0000_f000);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("register test done");
    apb(1'b1, `AWTC_BCR_OFF, 32'h0);
    for (int i = 0; i < 13; i++)
    begin
      apb(1'b1, `AWTC_WCR_OFF, {19'h0, 2'(i), 4'(i), 1'b1, 4'h0, 2'(i + 1)});
      acc(1'b1, 24'(i), 16'ha5c3 ^ 16'(i));
      chk("write latency", 32'(lat), 32'(2 * (i % 4) + 2 * wc_tab[i] + 2 * ((i + 1) % 4) + 5));
      acc(1'b0, 24'(i), 16'h0);
      chk("read latency", 32'(lat), 32'(2 * (i % 4) + 2 * wc_tab[i] + 2 * ((i + 1) % 4) + 5));
      chk("read data", {16'h0, rsp_rdata}, {16'h0, 16'ha5c3 ^ 16'(i)});
    end
    $display("timing test done");
    // external wait, unmasked then masked, zero wait code
    apb(1'b1, `AWTC_WCR_OFF, 32'h0);
    slow <= 1'b1;
    acc(1'b0, 24'h0, 16'h0);
    chk("wait honoured", 32'(lat), 32'hd);
    apb(1'b1, `AWTC_WCR_OFF, 32'h0000_0040);
    acc(1'b0, 24'h0, 16'h0);
    chk("wait ignored", 32'(lat), 32'h5);
    @(posedge pclk);
    slow <= 1'b0;
    $display("wait test done");
    // memory kinds, supported and refused
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, `AWTC_BCR_OFF, {16'h0, 4'(k), 12'h0});
      apb(1'b1, `AWTC_WCR_OFF, 32'h0000_0040);
      acc(1'b0, 24'h1, 16'h0);
      chk("kind error", {31'h0, rsp_error}, 32'(!(k == 0 || k == 3)));
      chk("kind data", {16'h0, rsp_rdata}, (k == 0 || k == 3) ? 32'h0000_a5c2 : 32'h0);
    end
    $display("kind test done");
    // reset in mid access, normal space again
    apb(1'b1, `AWTC_BCR_OFF, 32'h0);
    @(posedge pclk);
    req_valid <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("select in access", {31'h0, area_select_n}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    req_valid <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("select idle", {31'h0, area_select_n}, 32'h1);
    presetn <= 1'b1;
    apb(1'b0, `AWTC_WCR_OFF, 32'h0);
    chk("wcr after reset", rd, `AWTC_WCR_RESET);
    acc(1'b0, 24'h0, 16'h0);
    chk("latency after reset", 32'(lat), 32'h21);
    chk("data after reset", {16'h0, rsp_rdata}, 32'h0000_a5c3);
    $display("reset test done");
    end_sim();
  end

  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_sim();
  end
endmodule : awtc_top_bench

bind awtc_top awtc_monitor mon_u (.*);
